// *** shared/rac_pkg.sv ***
package rac_pkg;

    // Clock rate and timing figures.
    localparam int CLK_MHZ = 50;
    localparam int ADC_CONV_US = 350;
    localparam int ADC_CONV_CYCLES = ADC_CONV_US * CLK_MHZ;
    localparam int SWRST_MIN_US = 50;
    localparam int SWRST_MAX_US = 470;
    localparam int SWRST_CYCLES = SWRST_MIN_US * CLK_MHZ;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h03;
    localparam logic [7:0] IDX_MODE_CTRL = 8'h08;
    localparam logic [7:0] IDX_OUTPUT_CLOCK_CONFIG = 8'h0A;
    localparam logic [7:0] IDX_CONVERTER_CONFIG = 8'h0F;
    localparam logic [7:0] IDX_SENSOR_OFFSET_TRIM = 8'h10;
    localparam logic [7:0] IDX_CONVERTER_RESULT = 8'h11;
    localparam logic [7:0] IDX_SENSOR_CONTROL = 8'h12;

    // Register decode codes.
    localparam logic [2:0] RS_NONE = 3'h0;
    localparam logic [2:0] RS_IRQ = 3'h1;
    localparam logic [2:0] RS_MODE = 3'h2;
    localparam logic [2:0] RS_OUTCLK = 3'h3;
    localparam logic [2:0] RS_CONV = 3'h4;
    localparam logic [2:0] RS_SOFFS = 3'h5;
    localparam logic [2:0] RS_RESULT = 3'h6;
    localparam logic [2:0] RS_TSCTL = 3'h7;

    // Reset values and field positions.
    localparam logic [5:0] OUTCLK_RESET = 6'h06;
    localparam logic [6:0] CONV_RESET = 7'h00;
    localparam logic [3:0] SOFFS_RESET = 4'h0;
    localparam logic [7:0] TSCTL_RESET = 8'h20;
    localparam int CONV_START_BIT = 7;
    localparam int MODE_SWRST_BIT = 7;
    localparam int OUTCLK_ENLFC_BIT = 3;
    localparam logic [2:0] MCLK_LF = 3'h7;

    // Operating modes.
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_TX = 2'h2;
    localparam logic [1:0] MODE_RX = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {CK_OFF = 3'b001, CK_RUN = 3'b010, CK_TAIL = 3'b100} rac_ck_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } rac_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rac_axi_rsp_t;

    typedef struct packed {
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [7:0] wData;
        logic wStrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [5:0] outClk;
        logic [6:0] convCfg;
        logic adcDone;
        logic adcBusy;
        logic [15:0] adcCnt;
        logic [7:0] result;
        logic [3:0] soffs;
        logic [7:0] tsCtl;
        logic [1:0] cmdMode;
        logic [1:0] effMode;
        logic irqPend;
        logic swrstAct;
        logic [11:0] swrstCnt;
        logic rstPin;
        rac_ck_t ck;
        logic [2:0] curSel;
        logic [5:0] tickCnt;
        logic clkLvl;
        logic [9:0] tailCnt;
        logic xtalEn;
    } rac_state_t;

endpackage : rac_pkg

// *** rtl/rac_aux_ctrl.sv ***
// Functional notes
// - Three-bit select gives 30,15,10,4,3,2,1 MHz, or 32.768 kHz for code 111.
// - All options except 4 MHz and 32.768 kHz divide the 30 MHz crystal by integers.
// - Output clock configuration resets to 06h, giving 1 MHz by default.
// - In sleep with low-frequency enable set, output 32.768 kHz regardless of select.
// - In sleep with low-frequency enable clear, stop driving the output clock.
// - Without substitute, run 0, 128, 256 or 512 extra cycles before stopping.
// - A pending interrupt keeps the output clock and crystal running in any mode.
// - Mode change waits until the interrupt status has been read.
// - Writing 1 to bit 7 of converter configuration starts a new conversion.
// - Start/done bit reads 0 while converting and becomes 1 on completion.
// - Each conversion completes 350 microseconds after its start.
// - Eight-bit result goes to the read-only result register; read after done.
// - Input select three bits, reference two bits; reset 00h is sensor on bandgap.
// - Amplifier gain comes from the two low bits of converter configuration.
// - Sensor offset is a four-bit low nibble; upper bits unused.
// - Any reset returns every configuration register to its default.
// - Software reset holds internal reset for 50 to 470 microseconds.
// - Reset drives the first pin and its inverse the second pin.
// - Sensor control register resets to 20h so the offset enable is set.
`timescale 1ns/1ps
`default_nettype none

module rac_aux_ctrl
    import rac_pkg::*;
#(
    parameter int ADC_CONV_CYC = ADC_CONV_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Register bus.
    input wire rac_axi_req_t axiReq,
    output rac_axi_rsp_t axiRsp,
    // Clock sources, ticks at twice the source rate.
    input wire logic xtalTick,
    input wire logic lfTick,
    // Radio side events and converter sample.
    input wire logic irqEvent,
    input wire logic [7:0] adcSample,
    // Output clock pin and crystal enable.
    output logic clockOutPin,
    output logic clockOutPinOe,
    output logic xtalEnable,
    // Reset pins.
    output logic resetOutPin,
    output logic resetOutPinN,
    // Analog controls, converter status and operating mode.
    output logic [2:0] adcInputSel,
    output logic [1:0] adcRefSel,
    output logic [1:0] adcGain,
    output logic [3:0] sensorOffset,
    output logic [7:0] sensorCtrl,
    output logic adcConverting,
    output logic [1:0] opMode
);

    if (ADC_CONV_CYC < 1 || ADC_CONV_CYC > 65535)
    begin : g_chk
        $error("ADC_CONV_CYC out of range");
    end

    localparam rac_state_t ST_INIT = '{outClk: OUTCLK_RESET, tsCtl: TSCTL_RESET, ck: CK_OFF,
        rstPin: 1'b1, xtalEn: 1'b1, default: '0};

    function automatic logic [2:0] decodeAddr(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        if (idx == IDX_IRQ_STATUS[5:0]) return RS_IRQ;
        if (idx == IDX_MODE_CTRL[5:0]) return RS_MODE;
        if (idx == IDX_OUTPUT_CLOCK_CONFIG[5:0]) return RS_OUTCLK;
        if (idx == IDX_CONVERTER_CONFIG[5:0]) return RS_CONV;
        if (idx == IDX_SENSOR_OFFSET_TRIM[5:0]) return RS_SOFFS;
        if (idx == IDX_CONVERTER_RESULT[5:0]) return RS_RESULT;
        if (idx == IDX_SENSOR_CONTROL[5:0]) return RS_TSCTL;
        return RS_NONE;
    endfunction : decodeAddr

    // Source ticks per output period; the 4 MHz option is 15 ticks, high 7, low 8.
    function automatic logic [5:0] periodTicks(input logic [2:0] sel);
        unique case (sel)
            3'h0: return 6'h02;
            3'h1: return 6'h04;
            3'h2: return 6'h06;
            3'h3: return 6'h0F;
            3'h4: return 6'h14;
            3'h5: return 6'h1E;
            3'h6: return 6'h3C;
            default: return 6'h02;
        endcase
    endfunction : periodTicks

    function automatic logic [9:0] tailCycles(input logic [1:0] code);
        unique case (code)
            2'h0: return 10'h000;
            2'h1: return 10'h080;
            2'h2: return 10'h100;
            default: return 10'h200;
        endcase
    endfunction : tailCycles

    rac_state_t s;
    rac_state_t n;

    logic awReady, wReady, arReady, awHs, wHs, arHs, doWrite, wrEn;
    logic [7:0] wrAddr, wrData;
    logic [2:0] wrSel, rdSel;
    logic srcTick, boundary, effSleep, wantRun, lfOn;
    logic [2:0] desiredSel;
    logic [5:0] period;
    logic [7:0] rdValue;

    assign awReady = !s.awHeld && !s.bvalid;
    assign wReady = !s.wHeld && !s.bvalid;
    assign arReady = !s.rvalid;
    assign awHs = axiReq.awvalid && awReady;
    assign wHs = axiReq.wvalid && wReady;
    assign arHs = axiReq.arvalid && arReady;
    assign doWrite = (s.awHeld || awHs) && (s.wHeld || wHs) && !s.bvalid;
    assign wrAddr = s.awHeld ? s.awAddr : axiReq.awaddr;
    assign wrData = s.wHeld ? s.wData : axiReq.wdata[7:0];
    assign wrEn = doWrite && (s.wHeld ? s.wStrb0 : axiReq.wstrb[0]);
    assign wrSel = decodeAddr(wrAddr);
    assign rdSel = decodeAddr(axiReq.araddr);

    // The effective mode only follows the command once the interrupt is read.
    assign effSleep = (s.effMode == MODE_SLEEP) && !s.irqPend;
    assign lfOn = s.outClk[OUTCLK_ENLFC_BIT];
    assign desiredSel = (effSleep && lfOn) ? MCLK_LF : s.outClk[2:0];
    assign wantRun = !effSleep || lfOn;
    assign srcTick = (s.curSel == MCLK_LF) ? lfTick : xtalTick;
    assign period = periodTicks(s.curSel);
    // The last tick of the low phase is the only point where the clock may change.
    assign boundary = srcTick && (s.tickCnt == 6'(period - 6'h01));

    always_comb
    begin
        unique case (rdSel)
            RS_IRQ: rdValue = {7'h00, s.irqPend};
            RS_MODE: rdValue = {2'h0, s.effMode, 2'h0, s.cmdMode};
            RS_OUTCLK: rdValue = {2'h0, s.outClk};
            RS_CONV: rdValue = {s.adcDone, s.convCfg};
            RS_SOFFS: rdValue = {4'h0, s.soffs};
            RS_RESULT: rdValue = s.result;
            RS_TSCTL: rdValue = s.tsCtl;
            default: rdValue = 8'h00;
        endcase
    end

    always_comb
    begin
        n = s;
        // Write channel.
        if (awHs)
        begin
            n.awHeld = 1'b1;
            n.awAddr = axiReq.awaddr;
        end
        if (wHs)
        begin
            n.wHeld = 1'b1;
            n.wData = axiReq.wdata[7:0];
            n.wStrb0 = axiReq.wstrb[0];
        end
        if (doWrite)
        begin
            n.awHeld = 1'b0;
            n.wHeld = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = (wrSel == RS_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (s.bvalid && axiReq.bready)
        begin
            n.bvalid = 1'b0;
        end
        // Read channel.
        if (arHs)
        begin
            n.rvalid = 1'b1;
            n.rdata = rdValue;
            n.rresp = (rdSel == RS_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s.rvalid && axiReq.rready)
        begin
            n.rvalid = 1'b0;
        end

        // Converter timing; a new start write restarts the count.
        if (s.adcBusy)
        begin
            n.adcCnt = 16'(s.adcCnt + 16'h0001);
            if (s.adcCnt == 16'(ADC_CONV_CYC - 1))
            begin
                n.adcBusy = 1'b0;
                n.adcDone = 1'b1;
                n.result = adcSample;
            end
        end

        // Register writes.
        if (wrEn)
        begin
            unique case (wrSel)
                RS_MODE:
                begin
                    n.cmdMode = wrData[1:0];
                    if (wrData[MODE_SWRST_BIT])
                    begin
                        n.swrstAct = 1'b1;
                        n.swrstCnt = 12'h000;
                    end
                end
                RS_OUTCLK: n.outClk = wrData[5:0];
                RS_CONV:
                begin
                    n.convCfg = wrData[6:0];
                    if (wrData[CONV_START_BIT])
                    begin
                        n.adcBusy = 1'b1;
                        n.adcDone = 1'b0;
                        n.adcCnt = 16'h0000;
                    end
                end
                RS_SOFFS: n.soffs = wrData[3:0];
                RS_TSCTL: n.tsCtl = wrData;
                default: n.cmdMode = n.cmdMode;
            endcase
        end

        // Interrupt status clears on read; a new event in the same cycle wins.
        n.irqPend = irqEvent || (s.irqPend && !(arHs && rdSel == RS_IRQ));
        if (!s.irqPend)
        begin
            n.effMode = s.cmdMode;
        end

        // Output clock generator.
        unique case (s.ck)
            CK_OFF:
            begin
                n.tickCnt = 6'h00;
                n.clkLvl = 1'b0;
                if (wantRun)
                begin
                    n.ck = CK_RUN;
                    n.curSel = desiredSel;
                    n.clkLvl = 1'b1;
                end
            end
            CK_RUN, CK_TAIL:
            begin
                if (boundary)
                begin
                    n.tickCnt = 6'h00;
                    if (wantRun)
                    begin
                        n.ck = CK_RUN;
                        n.curSel = desiredSel;
                    end
                    else if (s.ck == CK_RUN)
                    begin
                        n.tailCnt = tailCycles(s.outClk[5:4]);
                        n.ck = (n.tailCnt == 10'h000) ? CK_OFF : CK_TAIL;
                    end
                    else if (s.tailCnt == 10'h001)
                    begin
                        n.ck = CK_OFF;
                    end
                    else
                    begin
                        n.tailCnt = 10'(s.tailCnt - 10'h001);
                    end
                    n.clkLvl = (n.ck != CK_OFF);
                end
                else if (srcTick)
                begin
                    n.tickCnt = 6'(s.tickCnt + 6'h01);
                    n.clkLvl = (n.tickCnt < {1'b0, period[5:1]});
                end
            end
            default:
            begin
                n.ck = CK_OFF;
                n.clkLvl = 1'b0;
            end
        endcase
        // The crystal stays on while awake or while the clock still needs it.
        n.xtalEn = !effSleep || (n.ck != CK_OFF && n.curSel != MCLK_LF);

        // Software reset pulse holds the configuration at its defaults.
        if (s.swrstAct)
        begin
            n.swrstCnt = 12'(s.swrstCnt + 12'h001);
            if (s.swrstCnt == 12'(SWRST_CYCLES - 1))
            begin
                n.swrstAct = 1'b0;
            end
            n.outClk = OUTCLK_RESET;
            n.convCfg = CONV_RESET;
            n.adcDone = 1'b0;
            n.adcBusy = 1'b0;
            n.soffs = SOFFS_RESET;
            n.tsCtl = TSCTL_RESET;
            n.cmdMode = MODE_IDLE;
            n.irqPend = 1'b0;
        end
        n.rstPin = n.swrstAct;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= ST_INIT;
        end
        else
        begin
            s <= n;
        end
    end

    assign axiRsp = '{awready: awReady, wready: wReady, bvalid: s.bvalid, bresp: s.bresp,
        arready: arReady, rvalid: s.rvalid, rdata: {24'h000000, s.rdata}, rresp: s.rresp};
    assign clockOutPin = s.clkLvl;
    assign clockOutPinOe = (s.ck != CK_OFF);
    assign xtalEnable = s.xtalEn;
    assign resetOutPin = s.rstPin;
    assign resetOutPinN = !s.rstPin;
    assign adcInputSel = s.convCfg[6:4];
    assign adcRefSel = s.convCfg[3:2];
    assign adcGain = s.convCfg[1:0];
    assign sensorOffset = s.soffs;
    assign sensorCtrl = s.tsCtl;
    assign adcConverting = s.adcBusy;
    assign opMode = s.effMode;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    property p_clk_sel;
        (s.ck != CK_OFF) |-> (s.tickCnt < periodTicks(s.curSel));
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("divider count past period");

    property p_swrst_default;
        s.swrstAct |=> (s.outClk == OUTCLK_RESET && s.tsCtl == TSCTL_RESET && !s.adcBusy);
    endproperty
    a_swrst_default: assert property (p_swrst_default) else $error("defaults lost");

    property p_lf_switch;
        (s.ck == CK_RUN && boundary && effSleep && lfOn) |=> (s.curSel == MCLK_LF);
    endproperty
    a_lf_switch: assert property (p_lf_switch) else $error("no low-frequency clock");

    property p_off_quiet;
        (s.ck == CK_OFF) |-> (!clockOutPinOe && !clockOutPin);
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("pin driven while off");

    property p_tail_entry;
        (s.ck == CK_RUN && boundary && !wantRun && s.outClk[5:4] != 2'h0)
            |=> (s.ck == CK_TAIL && s.tailCnt == tailCycles($past(s.outClk[5:4])));
    endproperty
    a_tail_entry: assert property (p_tail_entry) else $error("tail not started");

    property p_irq_run;
        (s.irqPend && $past(s.irqPend)) |-> (s.ck != CK_OFF && xtalEnable);
    endproperty
    a_irq_run: assert property (p_irq_run) else $error("clock stopped with irq");

    property p_mode_hold;
        (s.irqPend && !s.swrstAct) |=> (s.effMode == $past(s.effMode));
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved with irq");

    property p_adc_start;
        (wrEn && wrSel == RS_CONV && wrData[CONV_START_BIT] && !s.swrstAct)
            |=> (s.adcBusy && s.adcCnt == 16'h0000 && !s.adcDone);
    endproperty
    a_adc_start: assert property (p_adc_start) else $error("start ignored");

    property p_busy_reads_zero;
        s.adcBusy |-> !s.adcDone;
    endproperty
    a_busy_reads_zero: assert property (p_busy_reads_zero) else $error("done while busy");

    property p_conv_time;
        ($fell(s.adcBusy) && !$past(s.swrstAct))
            |-> ($past(s.adcCnt) == 16'(ADC_CONV_CYC - 1) && s.adcDone);
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

    property p_result;
        ($rose(s.adcDone)) |-> (s.result == $past(adcSample));
    endproperty
    a_result: assert property (p_result) else $error("result not captured");

    property p_swrst_len;
        ($fell(s.swrstAct)) |-> ($past(s.swrstCnt) == 12'(SWRST_CYCLES - 1));
    endproperty
    a_swrst_len: assert property (p_swrst_len) else $error("soft reset length wrong");

    property p_rst_pins;
        (resetOutPinN == !resetOutPin) and (s.swrstAct == resetOutPin);
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("reset pins disagree");

    property p_glitch_free;
        $changed(s.curSel) |-> !$past(s.clkLvl);
    endproperty
    a_glitch_free: assert property (p_glitch_free) else $error("switch while high");

    c_adc_done: cover property ($rose(s.adcDone));
    c_tail: cover property (s.ck == CK_TAIL ##1 s.ck == CK_OFF);
    c_swrst: cover property ($fell(s.swrstAct));
    c_lf: cover property (s.ck == CK_RUN && s.curSel == MCLK_LF);

endmodule : rac_aux_ctrl

`default_nettype wire

// *** dv/rac_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module rac_host_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Device pins.
    input wire logic clockOutPin,
    input wire logic xtalEnable,
    // Clock sources.
    output logic xtalTick,
    output logic lfTick,
    // Measurements.
    output var int period,
    output var int rises
);
    logic prevPin;
    logic [1:0] lfCnt;
    int cnt;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            xtalTick <= 1'h0;
            lfTick <= 1'h0;
            lfCnt <= 2'h0;
            prevPin <= 1'h0;
            cnt <= 0;
            period <= 0;
            rises <= 0;
        end
        else
        begin
            // A disabled crystal gives no ticks, so a wrong enable shows at the pin.
            xtalTick <= xtalEnable;
            lfCnt <= lfCnt + 2'h1;
            lfTick <= (lfCnt == 2'h3);
            prevPin <= clockOutPin;
            cnt <= cnt + 1;
            if (clockOutPin && !prevPin)
            begin
                period <= cnt + 1;
                cnt <= 0;
                rises <= rises + 1;
            end
        end
    end
endmodule : rac_host_model

`default_nettype wire

// *** dv/test_rac_aux_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_rac_aux_ctrl;
    import rac_pkg::*;
    localparam int CONV = 40;
    logic clock;
    logic sys_rst;
    rac_axi_req_t req;
    rac_axi_rsp_t rsp;
    logic xtalTick, lfTick, irqEvent, adcConverting;
    logic clockOutPin, clockOutPinOe, xtalEnable, resetOutPin, resetOutPinN;
    logic [7:0] adcSample, sensorCtrl, d;
    logic [2:0] adcInputSel;
    logic [1:0] adcRefSel, adcGain, opMode, r;
    logic [3:0] sensorOffset;
    int period, rises, n_fail, checked, cyc, busyLen, n;
    int perTab[8] = '{2, 4, 6, 15, 20, 30, 60, 8};
    logic [7:0] rA[4] = '{8'h28, 8'h3C, 8'h40, 8'h48};
    logic [7:0] rV[4] = '{8'h06, 8'h00, 8'h00, 8'h20};

    rac_aux_ctrl #(.ADC_CONV_CYC(CONV)) rac_aux_ctrl_inst (.clock(clock), .sys_rst(sys_rst),
        .axiReq(req), .axiRsp(rsp), .xtalTick(xtalTick), .lfTick(lfTick), .irqEvent(irqEvent),
        .adcSample(adcSample), .clockOutPin(clockOutPin), .clockOutPinOe(clockOutPinOe),
        .xtalEnable(xtalEnable), .resetOutPin(resetOutPin), .resetOutPinN(resetOutPinN),
        .adcInputSel(adcInputSel), .adcRefSel(adcRefSel), .adcGain(adcGain),
        .sensorOffset(sensorOffset), .sensorCtrl(sensorCtrl), .adcConverting(adcConverting),
        .opMode(opMode));
    rac_host_model rac_host_model_inst (.clock(clock), .sys_rst(sys_rst),
        .clockOutPin(clockOutPin), .xtalEnable(xtalEnable), .xtalTick(xtalTick),
        .lfTick(lfTick), .period(period), .rises(rises));

    initial
    begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    task end_sim;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    always @(posedge clock)
    begin
        cyc++;
        if (adcConverting === 1'h1)
            busyLen++;
        if (cyc == 40000)
        begin
            n_fail++;
            end_sim();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : chk

    // Sampling at the falling edge keeps the handshake decision clear of edge races.
    task wr(input logic [7:0] a, input logic [7:0] v);
        logic ta, tw, tb;
        @(posedge clock);
        req.awvalid <= 1'h1;
        req.awaddr <= a;
        req.wvalid <= 1'h1;
        req.wdata <= {24'h0, v};
        req.wstrb <= 4'hF;
        req.bready <= 1'h1;
        do
        begin
            @(negedge clock);
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tb = rsp.bvalid;
            r = rsp.bresp;
            @(posedge clock);
            if (ta)
                req.awvalid <= 1'h0;
            if (tw)
                req.wvalid <= 1'h0;
            if (tb)
                req.bready <= 1'h0;
        end while (!tb);
    endtask : wr

    task rdr(input logic [7:0] a);
        logic ta, tr;
        @(posedge clock);
        req.arvalid <= 1'h1;
        req.araddr <= a;
        req.rready <= 1'h1;
        do
        begin
            @(negedge clock);
            ta = req.arvalid && rsp.arready;
            tr = rsp.rvalid;
            d = rsp.rdata[7:0];
            r = rsp.rresp;
            @(posedge clock);
            if (ta)
                req.arvalid <= 1'h0;
            if (tr)
                req.rready <= 1'h0;
        end while (!tr);
    endtask : rdr

    task conv(input logic [7:0] smp);
        adcSample <= smp;
        busyLen = 0;
        wr(8'h3C, 8'hB5);
        rdr(8'h3C);
        chk("startdone busy", 8'h35, d);
        for (int k = 0; k < 200 && adcConverting !== 1'h0; k++)
            @(negedge clock);
        chk("conv cycles", CONV, busyLen);
        rdr(8'h3C);
        chk("startdone done", 8'hB5, d);
        rdr(8'h44);
        chk("result", smp, d);
    endtask : conv

    initial
    begin
        sys_rst = 1'h1;
        req = '0;
        irqEvent = 1'h0;
        adcSample = 8'h00;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'h0;
        @(negedge clock);
        chk("rst pins held", 2'h2, {resetOutPin, resetOutPinN});
        @(negedge clock);
        chk("rst pins", 2'h1, {resetOutPin, resetOutPinN});
        for (int i = 0; i < 4; i++)
        begin
            rdr(rA[i]);
            chk("reset value", rV[i], d);
        end
        rdr(8'h80);
        chk("unmapped resp", RESP_SLVERR, r);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h28, i[7:0]);
            repeat (200) @(negedge clock);
            chk("clock period", perTab[i], period);
        end
        wr(8'h28, 8'h08);
        wr(8'h20, 8'h01);
        repeat (100) @(negedge clock);
        chk("sleep lf period", 8, period);
        chk("sleep mode", MODE_SLEEP, opMode);
        wr(8'h20, 8'h00);
        wr(8'h28, 8'h10);
        repeat (50) @(negedge clock);
        wr(8'h20, 8'h01);
        // Count from the edge at which sleep takes effect, not from the write.
        for (int k = 0; k < 20 && opMode !== MODE_SLEEP; k++)
            @(negedge clock);
        n = rises;
        for (int k = 0; k < 2000 && clockOutPinOe !== 1'h0; k++)
            @(negedge clock);
        chk("tail periods", 1'h1, (rises - n) inside {128, 129});
        chk("stopped pin", 2'h0, {clockOutPin, clockOutPinOe});
        $display("test clock done");
        wr(8'h20, 8'h00);
        repeat (100) @(posedge clock);
        irqEvent <= 1'h1;
        @(posedge clock);
        irqEvent <= 1'h0;
        wr(8'h20, 8'h01);
        repeat (200) @(negedge clock);
        chk("held clock", 2'h3, {clockOutPinOe, xtalEnable});
        chk("held mode", MODE_IDLE, opMode);
        rdr(8'h0C);
        chk("irq pending", 1'h1, d[0]);
        repeat (3) @(negedge clock);
        chk("mode after read", MODE_SLEEP, opMode);
        wr(8'h20, 8'h00);
        $display("test irq done");
        conv(8'hA5);
        chk("conv fields", 7'h35, {adcInputSel, adcRefSel, adcGain});
        wr(8'h44, 8'h00);
        rdr(8'h44);
        chk("result ro", 8'hA5, d);
        conv(8'h3C);
        wr(8'h40, 8'hFF);
        rdr(8'h40);
        chk("offset", 8'h0F, d);
        chk("offset pin", 4'hF, sensorOffset);
        $display("test adc done");
        wr(8'h28, 8'h3F);
        wr(8'h20, 8'h80);
        for (int k = 0; k < 20 && resetOutPin !== 1'h1; k++)
            @(negedge clock);
        n = 0;
        while (resetOutPin === 1'h1 && n < 30000)
        begin
            @(negedge clock);
            n++;
        end
        chk("soft reset len", SWRST_CYCLES, n);
        chk("soft reset span", 1'h1, n >= 2500 && n <= 23500);
        rdr(8'h28);
        chk("outclk after soft reset", 8'h06, d);
        rdr(8'h40);
        chk("offset after soft reset", 8'h00, d);
        $display("test soft reset done");
        end_sim();
    end
endmodule : test_rac_aux_ctrl

`default_nettype wire
